/* File: rtl/pc_fetch_unit.sv */
// Program counter, program memory map and interrupt vectoring for the core.
// Assumes a synchronous flash that returns the word for flash_addr one
// cycle after flash_rd_en, and a core that raises one request per cycle.
`timescale 1ns/10ps
//Contract
// - 21-bit program counter spans 2 Mbyte
// - Fetch starts at address zero after reset
// - Two interrupt vectors at 0x0008, 0x0018
// - Flash size parameter: 32 or 16 Kbytes
// - Fetch beyond flash returns zero word
// - Separate program and data buses
// - Enabled interrupt wake loads matching vector
// - Enabled interrupt wake pushes current PC to stack
// - Enabled interrupt wake advances stack pointer until it is full
// - Interrupt wake sets request flag bits
// - Unimplemented register bits read zero
// - Stack: 31x21 bits, pointer resets zero
// - Push increments pointer, then writes entry
module pc_fetch_unit
    import pmm_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b1
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire logic                   step,
    input  wire branch_s                branch,
    input  wire logic                   ret_req,
    input  wire logic                   irq_wake,
    input  wire logic                   irq_high_prio,
    input  wire logic                   high_priority_global_irq_enable,
    input  wire logic                   low_priority_global_irq_enable,
    input  wire logic [FLAG_W-1:0]      irq_flag_clr,
    input  wire logic [1:0]             stack_flag_clr,
    input  wire logic [INSTR_W-1:0]     flash_rdata,
    input  wire data_req_s              data_req,
    input  wire logic [DATA_W-1:0]      data_rdata,
    output logic      [PC_W-1:0]        flash_addr,
    output logic                        flash_rd_en,
    output logic      [INSTR_W-1:0]     instr,
    output logic                        instr_valid,
    output logic      [PC_W-1:0]        instr_addr,
    output tos_s                        top_of_stack,
    output logic      [7:0]             return_stack_pointer,
    output logic      [FLAG_W-1:0]      interrupt_control_regs,
    output data_req_s                   data_bus_out,
    output logic      [DATA_W-1:0]      data_rdata_out
);

    // The implemented flash size is fixed per build; the rest of the
    // 2 Mbyte space is decoded rather than stored.
    localparam logic [PC_W-1:0] FLASH_BYTES =
        LARGE_FLASH ? FLASH_BYTES_32K : FLASH_BYTES_16K;

    function automatic logic beyond_flash(input logic [PC_W-1:0] addr);
        beyond_flash = (addr >= FLASH_BYTES);
    endfunction

    fetch_state_e           state_reg;
    fetch_state_e           state_next;
    logic [PC_W-1:0]        pc_reg;
    logic [PC_W-1:0]        pc_next;
    logic                   rd_en_reg;
    logic                   rd_en_next;
    logic                   beyond_reg;
    logic                   beyond_next;
    logic                   rd_lag_reg;
    logic                   rd_lag_next;
    logic [PC_W-1:0]        addr_lag_reg;
    logic [PC_W-1:0]        addr_lag_next;
    logic [INSTR_W-1:0]     instr_reg;
    logic [INSTR_W-1:0]     instr_next;
    logic                   instr_valid_reg;
    logic                   instr_valid_next;
    logic [PC_W-1:0]        instr_addr_reg;
    logic [PC_W-1:0]        instr_addr_next;
    logic [FLAG_W-1:0]      flag_reg;
    logic [FLAG_W-1:0]      flag_next;
    tos_s                   tos_reg;
    data_req_s              data_out_reg;
    logic [DATA_W-1:0]      data_rdata_reg;
    logic                   irq_take;
    logic                   push;
    logic                   pop;
    logic [PC_W-1:0]        push_data;
    logic [SP_W-1:0]        sp;
    logic [PC_W-1:0]        stack_tos;
    logic                   stack_full;
    logic                   stack_unf;

    // A wake only vectors when the enable of its own priority is set.
    assign irq_take = irq_wake && (irq_high_prio
                      ? high_priority_global_irq_enable
                      : low_priority_global_irq_enable);

    always_comb begin
        state_next = ST_FETCH;
        pc_next    = pc_reg;
        push       = 1'b0;
        pop        = 1'b0;
        push_data  = pc_reg;
        case (state_reg)
            ST_RESET: begin
                pc_next = RESET_VEC;
            end
            ST_FETCH: begin
                if (irq_take) begin
                    push      = 1'b1;
                    push_data = pc_reg;
                    pc_next   = irq_high_prio ? HI_VEC : LO_VEC;
                end else if (ret_req) begin
                    // An underflowed pop yields zero and so lands on the
                    // reset vector.
                    pop     = 1'b1;
                    pc_next = stack_tos;
                end else if (branch.valid) begin
                    push      = branch.call;
                    push_data = PC_W'(pc_reg + PC_STEP);
                    pc_next   = branch.target;
                end else if (step) begin
                    pc_next = PC_W'(pc_reg + PC_STEP);
                end
            end
            default: begin
                pc_next = RESET_VEC;
            end
        endcase
    end

    always_comb begin
        rd_en_next       = (state_reg == ST_FETCH);
        // The read issued at the last edge answers now; its address and
        // range flag travel beside it so word and address stay paired.
        rd_lag_next      = rd_en_reg;
        addr_lag_next    = pc_reg;
        beyond_next      = beyond_flash(pc_reg);
        instr_addr_next  = rd_lag_reg ? addr_lag_reg : instr_addr_reg;
        instr_valid_next = rd_lag_reg;
        instr_next       = instr_reg;
        if (rd_lag_reg) begin
            instr_next = beyond_reg ? INSTR_NOP : flash_rdata;
        end
        // A new wake wins over a clear landing in the same cycle.
        flag_next = flag_reg & ~irq_flag_clr;
        if (irq_wake) begin
            flag_next[irq_high_prio ? FLAG_HI_BIT : FLAG_LO_BIT] = 1'b1;
        end
    end

    // The address lags by one so flash data lines up with beyond_reg.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= ST_RESET;
            pc_reg          <= RESET_VEC;
            rd_en_reg       <= 1'b0;
            beyond_reg      <= 1'b0;
            rd_lag_reg      <= 1'b0;
            addr_lag_reg    <= RESET_VEC;
            instr_reg       <= INSTR_NOP;
            instr_valid_reg <= 1'b0;
            instr_addr_reg  <= RESET_VEC;
            flag_reg        <= '0;
            tos_reg         <= '0;
            data_out_reg    <= '0;
            data_rdata_reg  <= '0;
        end else if (clk_en) begin
            state_reg       <= state_next;
            pc_reg          <= pc_next;
            rd_en_reg       <= rd_en_next;
            beyond_reg      <= beyond_next;
            rd_lag_reg      <= rd_lag_next;
            addr_lag_reg    <= addr_lag_next;
            instr_reg       <= instr_next;
            instr_valid_reg <= instr_valid_next;
            instr_addr_reg  <= instr_addr_next;
            flag_reg        <= flag_next;
            tos_reg         <= tos_s'(stack_tos);
            // Data traffic has its own path and never waits on a fetch.
            data_out_reg    <= data_req;
            data_rdata_reg  <= data_rdata;
        end
    end

    return_stack u_stack (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .clk_en        (clk_en),
        .push          (push),
        .pop           (pop),
        .push_data     (push_data),
        .flag_clr      (stack_flag_clr),
        .sp_reg        (sp),
        .tos           (stack_tos),
        .full_reg      (stack_full),
        .underflow_reg (stack_unf)
    );

    assign flash_addr             = pc_reg;
    assign flash_rd_en            = rd_en_reg;
    assign instr                  = instr_reg;
    assign instr_valid            = instr_valid_reg;
    assign instr_addr             = instr_addr_reg;
    assign top_of_stack           = tos_reg;
    assign return_stack_pointer   = {stack_full, stack_unf, 1'b0, sp};
    assign interrupt_control_regs = flag_reg;
    assign data_bus_out           = data_out_reg;
    assign data_rdata_out         = data_rdata_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    reset_fetch_start_a: assert property (
        state_reg == ST_RESET |-> pc_reg == RESET_VEC && !rd_en_reg)
        else $error("fetch did not start at address zero");

    pc_step_two_a: assert property (
        clk_en && state_reg == ST_FETCH && step && !irq_take
        && !ret_req && !branch.valid
        |=> pc_reg == PC_W'($past(pc_reg) + PC_STEP))
        else $error("sequential step did not add two");

    hi_vector_a: assert property (
        clk_en && state_reg == ST_FETCH && irq_wake && irq_high_prio
        && high_priority_global_irq_enable |=> pc_reg == HI_VEC)
        else $error("high wake missed vector 0x0008");

    lo_vector_a: assert property (
        clk_en && state_reg == ST_FETCH && irq_wake && !irq_high_prio
        && low_priority_global_irq_enable |=> pc_reg == LO_VEC)
        else $error("low wake missed vector 0x0018");

    irq_push_pc_a: assert property (
        clk_en && state_reg == ST_FETCH && irq_take && sp != SP_FULL
        ##1 clk_en |=> top_of_stack == tos_s'($past(pc_reg, 2)))
        else $error("interrupt did not push current pc");

    irq_sp_bump_a: assert property (
        clk_en && state_reg == ST_FETCH && irq_take && sp != SP_FULL
        |=> sp == SP_W'($past(sp) + SP_ONE))
        else $error("interrupt did not advance stack pointer");

    wake_flag_set_a: assert property (
        clk_en && irq_wake |=> interrupt_control_regs != '0)
        else $error("wake left no request flag set");

    beyond_flash_zero_a: assert property (
        clk_en && flash_rd_en && beyond_flash(flash_addr) ##1 clk_en
        |=> instr == INSTR_NOP && instr_valid)
        else $error("fetch beyond flash returned nonzero");

    reserved_bit_zero_a: assert property (
        return_stack_pointer[STK_RSV_BIT] == 1'b0)
        else $error("reserved status bit reads one");

    data_path_free_a: assert property (
        clk_en && data_req.valid && rd_en_reg
        |=> data_bus_out == $past(data_req))
        else $error("data access stalled by fetch");

    cover_hi_irq_c: cover property (
        clk_en && irq_take && irq_high_prio);
    cover_lo_irq_c: cover property (
        clk_en && irq_take && !irq_high_prio);
    cover_beyond_c: cover property (
        clk_en && flash_rd_en && beyond_flash(flash_addr));
    cover_underflow_c: cover property (
        clk_en && ret_req && sp == SP_RESET);

endmodule

/* File: rtl/pmm_pkg.sv */
// Shared constants and carrier types for the program address and fetch path.
// Assumes a byte-addressed program space with 16-bit instruction words.
package pmm_pkg;

    localparam int PC_W        = 21;
    localparam int SP_W        = 5;
    localparam int STACK_DEPTH = 31;
    localparam int INSTR_W     = 16;
    localparam int DATA_ADDR_W = 12;
    localparam int DATA_W      = 8;
    localparam int FLAG_W      = 2;

    localparam logic [PC_W-1:0] RESET_VEC       = 21'h00_0000;
    localparam logic [PC_W-1:0] HI_VEC          = 21'h00_0008;
    localparam logic [PC_W-1:0] LO_VEC          = 21'h00_0018;
    localparam logic [PC_W-1:0] PC_STEP         = 21'h00_0002;
    localparam logic [PC_W-1:0] FLASH_BYTES_32K = 21'h00_8000;
    localparam logic [PC_W-1:0] FLASH_BYTES_16K = 21'h00_4000;

    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [SP_W-1:0] SP_FULL  = 5'h1f;
    localparam logic [SP_W-1:0] SP_ONE   = 5'h01;

    localparam logic [INSTR_W-1:0] INSTR_NOP = 16'h0000;

    // Bit positions of the wake flags and of the stack status byte.
    localparam int FLAG_LO_BIT  = 0;
    localparam int FLAG_HI_BIT  = 1;
    localparam int STK_FULL_BIT = 7;
    localparam int STK_UNF_BIT  = 6;
    localparam int STK_RSV_BIT  = 5;

    typedef struct packed {
        logic [4:0] top_of_stack_upper;
        logic [7:0] top_of_stack_high;
        logic [7:0] top_of_stack_low;
    } tos_s;

    typedef struct packed {
        logic                   valid;
        logic                   call;
        logic [PC_W-1:0]        target;
    } branch_s;

    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [DATA_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]      wdata;
    } data_req_s;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_FETCH = 2'b01
    } fetch_state_e;

endpackage

/* File: rtl/return_stack.sv */
// Hardware return stack: 31 entries of 21 bits with a 5-bit pointer.
// Assumes the caller never asks for push and pop in the same cycle;
// if it does, the push wins.
`timescale 1ns/10ps
module return_stack
    import pmm_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              push,
    input  wire logic              pop,
    input  wire logic [PC_W-1:0]   push_data,
    input  wire logic [1:0]        flag_clr,
    output logic      [SP_W-1:0]   sp_reg,
    output logic      [PC_W-1:0]   tos,
    output logic                   full_reg,
    output logic                   underflow_reg
);

    logic [PC_W-1:0] entry_reg  [STACK_DEPTH:1];
    logic [PC_W-1:0] entry_next [STACK_DEPTH:1];
    logic [SP_W-1:0] sp_next;
    logic            full_next;
    logic            underflow_next;
    logic [SP_W-1:0] wr_idx;

    // Pointer zero owns no storage and reads back as zero.
    assign tos = (sp_reg == SP_RESET) ? '0 : entry_reg[sp_reg];

    always_comb begin
        entry_next     = entry_reg;
        sp_next        = sp_reg;
        full_next      = full_reg & ~flag_clr[0];
        underflow_next = underflow_reg & ~flag_clr[1];
        wr_idx = (sp_reg == SP_FULL) ? SP_FULL : SP_W'(sp_reg + SP_ONE);
        if (push) begin
            // Once full, further pushes overwrite the top entry.
            sp_next             = wr_idx;
            entry_next[wr_idx]  = push_data;
            if (wr_idx == SP_FULL) begin
                full_next = 1'b1;
            end
        end else if (pop) begin
            if (sp_reg == SP_RESET) begin
                underflow_next = 1'b1;
            end else begin
                sp_next = SP_W'(sp_reg - SP_ONE);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg        <= SP_RESET;
            full_reg      <= 1'b0;
            underflow_reg <= 1'b0;
            for (int i = 1; i <= STACK_DEPTH; i++) begin
                entry_reg[i] <= '0;
            end
        end else if (clk_en) begin
            sp_reg        <= sp_next;
            full_reg      <= full_next;
            underflow_reg <= underflow_next;
            entry_reg     <= entry_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    push_order_a: assert property (
        clk_en && push && sp_reg != SP_FULL
        |=> sp_reg == SP_W'($past(sp_reg) + SP_ONE)
            && tos == $past(push_data))
        else $error("push did not bump pointer then write top");

    stack_bound_a: assert property (
        sp_reg <= SP_FULL && (full_reg || !$rose(sp_reg == SP_FULL)))
        else $error("pointer past 31 or full flag missing");

endmodule

/* File: verification/flash_model.sv */
// Behavioural model of the on-chip program flash behind the fetch unit.
// Assumes a synchronous read: the word for flash_addr appears after an
// edge at which flash_rd_en is high.
`timescale 1ns/10ps
module flash_model
    import pmm_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               flash_rd_en,
    input  wire logic [PC_W-1:0]    flash_addr,
    output logic      [INSTR_W-1:0] flash_rdata
);
    // The pattern is never zero and is returned even above the implemented
    // array, so only the fetch unit itself can produce the zero word.
    initial flash_rdata = 16'hffff;

    always @(posedge clk_sys) begin
        if (flash_rd_en === 1'b1)
            flash_rdata <= {flash_addr[15:1], 1'b1} ^ 16'h5a5a;
        else
            flash_rdata <= ~flash_rdata;
    end
endmodule

/* File: verification/program_memory_map_vectoring_bench.sv */
// Self-checking bench for the program counter and fetch unit.
// Assumes the flash model on the far side; runs the 32 Kbyte and 16 Kbyte builds side by side.
`timescale 1ns/10ps
module program_memory_map_vectoring_bench;
    import pmm_pkg::*;

    logic                clk_sys = 1'b0;
    logic                rst_n, clk_en, step, ret_req, irq_wake;
    logic                irq_high_prio, hi_en, lo_en, full_e, unf_e;
    logic [1:0]          irq_flag_clr, stack_flag_clr;
    logic [DATA_W-1:0]   data_rdata, data_rdata_out, sp_byte;
    logic [PC_W-1:0]     flash_addr, instr_addr, exp_pc, instr_addr_16k;
    logic [INSTR_W-1:0]  flash_rdata, instr, instr_16k;
    logic [FLAG_W-1:0]   irq_flags;
    logic                flash_rd_en, instr_valid, instr_valid_16k;
    branch_s             branch;
    data_req_s           data_req, data_bus_out;
    tos_s                top_of_stack;
    logic [PC_W-1:0]     stk[$];
    int                  err_total = 0;
    int                  num_checks = 0;

    always #2.5 clk_sys = ~clk_sys;

    pc_fetch_unit #(.LARGE_FLASH(1'b1)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .step(step),
        .branch(branch), .ret_req(ret_req), .irq_wake(irq_wake),
        .irq_high_prio(irq_high_prio),
        .high_priority_global_irq_enable(hi_en),
        .low_priority_global_irq_enable(lo_en),
        .irq_flag_clr(irq_flag_clr), .stack_flag_clr(stack_flag_clr),
        .flash_rdata(flash_rdata), .data_req(data_req),
        .data_rdata(data_rdata), .flash_addr(flash_addr),
        .flash_rd_en(flash_rd_en), .instr(instr),
        .instr_valid(instr_valid), .instr_addr(instr_addr),
        .top_of_stack(top_of_stack),
        .return_stack_pointer(sp_byte),
        .interrupt_control_regs(irq_flags),
        .data_bus_out(data_bus_out), .data_rdata_out(data_rdata_out));

    flash_model i_flash (
        .clk_sys(clk_sys), .flash_rd_en(flash_rd_en),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata));

    // The 16 Kbyte build walks the same pc path, so it shares the flash.
    pc_fetch_unit #(.LARGE_FLASH(1'b0)) i_dut_16k (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .step(step),
        .branch(branch), .ret_req(ret_req), .irq_wake(irq_wake),
        .irq_high_prio(irq_high_prio),
        .high_priority_global_irq_enable(hi_en),
        .low_priority_global_irq_enable(lo_en),
        .irq_flag_clr(irq_flag_clr), .stack_flag_clr(stack_flag_clr),
        .flash_rdata(flash_rdata), .data_req(data_req),
        .data_rdata(data_rdata), .flash_addr(),
        .flash_rd_en(), .instr(instr_16k),
        .instr_valid(instr_valid_16k), .instr_addr(instr_addr_16k),
        .top_of_stack(), .return_stack_pointer(),
        .interrupt_control_regs(), .data_bus_out(), .data_rdata_out());

    task automatic final_report();
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic go(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    function automatic logic [INSTR_W-1:0] exp_word(
        input logic [PC_W-1:0] a,
        input logic [PC_W-1:0] lim);
        if (a >= lim)
            return INSTR_NOP;
        return {a[15:1], 1'b1} ^ 16'h5a5a;
    endfunction

    function automatic logic [7:0] exp_sp();
        return {full_e, unf_e, 1'b0, 5'(stk.size())};
    endfunction

    // Every fresh fetch must carry the word of its own address.
    always @(negedge clk_sys) begin
        if (rst_n === 1'b1 && instr_valid === 1'b1)
            chk("instr", 32'(exp_word(instr_addr, FLASH_BYTES_32K)),
                32'(instr));
        if (rst_n === 1'b1 && instr_valid_16k === 1'b1)
            chk("instr 16k",
                32'(exp_word(instr_addr_16k, FLASH_BYTES_16K)),
                32'(instr_16k));
    end

    task automatic do_reset();
        rst_n = 1'b0;
        go(2);
        chk("reset pc", 0, flash_addr);
        chk("reset sp", 0, sp_byte);
        chk("reset flags", 0, irq_flags);
        rst_n = 1'b1;
        go(1);
        exp_pc = RESET_VEC;
        stk.delete();
        full_e = 1'b0;
        unf_e = 1'b0;
        chk("first pc", exp_pc, flash_addr);
        chk("first rd_en", 0, flash_rd_en);
        chk("first valid", 0, instr_valid);
    endtask

    task automatic t_fetch_data();
        for (int i = 0; i < 4; i++) begin
            data_req = '{1'b1, i[0], 12'h0a0 + 12'(i), 8'h3c ^ 8'(i)};
            data_rdata = 8'hc3 + 8'(i);
            step = 1'b1;
            go(1);
            exp_pc = exp_pc + PC_STEP;
            chk("step pc", exp_pc, flash_addr);
            chk("data bus", data_req, data_bus_out);
            chk("data read", data_rdata, data_rdata_out);
        end
        step = 1'b0;
        data_req = '0;
    endtask

    task automatic jump(input logic [PC_W-1:0] tgt, input logic call);
        branch = '{1'b1, call, tgt};
        go(1);
        branch = '0;
        if (call) begin
            if (stk.size() == STACK_DEPTH)
                stk[STACK_DEPTH-1] = exp_pc + PC_STEP;
            else
                stk.push_back(exp_pc + PC_STEP);
            if (stk.size() == STACK_DEPTH)
                full_e = 1'b1;
        end
        exp_pc = tgt;
        chk("branch pc", exp_pc, flash_addr);
        chk("branch sp", exp_sp(), sp_byte);
        go(1);
        if (call)
            chk("pushed", stk[$], top_of_stack);
    endtask

    task automatic t_branch_map();
        jump(21'h1f_fffe, 1'b0);
        jump(21'h00_7ffe, 1'b0);
        go(2);
        chk("top word", exp_word(exp_pc, FLASH_BYTES_32K), instr);
        chk("small top word", INSTR_NOP, instr_16k);
        step = 1'b1;
        go(1);
        step = 1'b0;
        exp_pc = FLASH_BYTES_32K;
        go(3);
        chk("beyond pc", exp_pc, instr_addr);
        chk("beyond word", INSTR_NOP, instr);
        chk("beyond valid", 1, instr_valid);
    endtask

    task automatic t_freeze();
        clk_en = 1'b0;
        step = 1'b1;
        go(2);
        chk("frozen pc", exp_pc, flash_addr);
        clk_en = 1'b1;
        step = 1'b0;
    endtask

    task automatic t_irq(input logic prio, input logic hen, input logic len);
        logic [PC_W-1:0] old;
        old = exp_pc;
        irq_flag_clr = 2'b11;
        go(1);
        irq_flag_clr = 2'b00;
        irq_wake = 1'b1;
        irq_high_prio = prio;
        hi_en = hen;
        lo_en = len;
        go(1);
        irq_wake = 1'b0;
        if (prio ? hen : len) begin
            exp_pc = prio ? HI_VEC : LO_VEC;
            stk.push_back(old);
        end
        chk("vector", exp_pc, flash_addr);
        chk("flags", prio ? 2'b10 : 2'b01, irq_flags);
        chk("irq sp", exp_sp(), sp_byte);
        go(1);
        if (prio ? hen : len)
            chk("irq tos", old, top_of_stack);
    endtask

    task automatic t_return();
        ret_req = 1'b1;
        go(1);
        ret_req = 1'b0;
        if (stk.size() == 0) begin
            exp_pc = RESET_VEC;
            unf_e = 1'b1;
        end
        else
            exp_pc = stk.pop_back();
        chk("return pc", exp_pc, flash_addr);
        chk("return sp", exp_sp(), sp_byte);
        go(1);
    endtask

    task automatic t_stack();
        for (int i = 0; i < 32; i++)
            jump(21'h00_0100 + 21'(i * 4), 1'b1);
        stack_flag_clr = 2'b01;
        go(1);
        stack_flag_clr = 2'b00;
        full_e = 1'b0;
        chk("full clear", exp_sp(), sp_byte);
        repeat (32) t_return();
        stack_flag_clr = 2'b10;
        go(1);
        stack_flag_clr = 2'b00;
        unf_e = 1'b0;
        chk("underflow clear", exp_sp(), sp_byte);
    endtask

    initial begin
        #200000;
        err_total++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        {step, ret_req, irq_wake, irq_high_prio, hi_en, lo_en} = '0;
        {irq_flag_clr, stack_flag_clr} = '0;
        branch = '0;
        data_req = '0;
        data_rdata = 8'h00;
        do_reset();
        t_fetch_data();
        t_branch_map();
        t_freeze();
        t_irq(1'b1, 1'b1, 1'b0);
        t_irq(1'b0, 1'b1, 1'b1);
        t_irq(1'b1, 1'b0, 1'b1);
        do_reset();
        t_stack();
        final_report();
    end
endmodule
